// File: verilog/brio_pkg.sv
package brio_pkg;
  // ---------------------------------------------------------------
  // remote word map
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned WORD_ADDR_W   = 7;
  localparam logic [6:0]  WORD_STATUS   = 7'h00;
  localparam logic [6:0]  WORD_EVENT    = 7'h01;
  localparam logic [6:0]  WORD_IMG_BASE = 7'h04;
  localparam logic [6:0]  WORD_IMG_LAST = 7'h13;
  localparam int unsigned IMG_WORDS     = 16;
  localparam int unsigned IMG_POINTS    = 256;

  // ---------------------------------------------------------------
  // bit positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_READY       = 0;
  localparam int unsigned BIT_SHORT       = 1;
  localparam int unsigned BIT_VDROP       = 3;
  localparam int unsigned BIT_DISC        = 4;
  localparam int unsigned BIT_ALARM       = 0;
  localparam int unsigned BIT_PACC_DONE   = 1;
  localparam int unsigned BIT_PACC_ERR    = 2;
  localparam int unsigned BIT_ADDR_DET    = 4;
  localparam int unsigned BIT_ERR_RESET   = 0;
  localparam int unsigned BIT_ADDR_CMD    = 1;
  localparam int unsigned BIT_PACC_REQ    = 0;
  localparam int unsigned BIT_BATCH_READ  = 1;
  localparam int unsigned BIT_BATCH_WRITE = 2;

  // writable masks: prohibited output bits are dropped
  localparam logic [15:0] CMD_MASK   = 16'h0003;
  localparam logic [15:0] PARAM_MASK = 16'h0007;

  // ---------------------------------------------------------------
  // station number and point count
  // ---------------------------------------------------------------
  localparam logic [6:0]  STATION_MIN = 7'h01;
  localparam logic [6:0]  STATION_MAX = 7'h78;
  localparam logic [6:0]  TENS_WEIGHT = 7'h0A;
  localparam logic [3:0]  DIGIT_MAX   = 4'h9;
  localparam logic [8:0]  POINTS_256  = 9'h100;
  localparam logic [8:0]  POINTS_128  = 9'h080;
  localparam logic [8:0]  POINTS_64   = 9'h040;
  localparam logic [8:0]  POINTS_32   = 9'h020;
  localparam logic [2:0]  OCC_256     = 3'h4;
  localparam logic [2:0]  OCC_128     = 3'h2;
  localparam logic [2:0]  OCC_64      = 3'h1;
  localparam logic [2:0]  OCC_32      = 3'h1;
  localparam logic [2:0]  CYC_256     = 3'h3;
  localparam logic [2:0]  CYC_128     = 3'h2;
  localparam logic [2:0]  CYC_64      = 3'h1;
  localparam logic [2:0]  CYC_32      = 3'h0;

  typedef struct packed {
    logic short_err;
    logic vdrop_err;
    logic disc_err;
    logic alarm;
    logic pacc_done;
    logic pacc_err;
    logic addr_det;
  } brio_event_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] number;
  } brio_station_s;
endpackage

// File: verilog/brio_remote_io_map.sv
`timescale 1ns/1ps
module brio_remote_io_map (
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic [3:0]                i_station_tens,
  input  wire logic [3:0]                i_station_ones,
  input  wire logic                      i_station_duplicate,
  input  wire logic                      i_point_count_select_low,
  input  wire logic                      i_point_count_select_high,
  input  wire logic                      i_test_done,
  input  wire logic                      i_hw_failure,
  input  wire brio_pkg::brio_event_s     i_event,
  input  wire logic [255:0]              i_sensor_points,
  input  wire logic                      i_wr_en,
  input  wire logic                      i_rd_en,
  input  wire logic [6:0]                i_addr,
  input  wire logic [15:0]               i_wdata,
  output logic      [15:0]               o_rdata,
  output logic                           o_error_led,
  output logic                           o_station_accepted,
  output brio_pkg::brio_station_s        o_station,
  output logic      [8:0]                o_point_count,
  output logic      [2:0]                o_occupied_stations,
  output logic      [2:0]                o_cycle_code,
  output logic                           o_error_reset_request,
  output logic                           o_addr_detect_command,
  output logic                           o_param_access_request,
  output logic                           o_param_batch_read_cmd,
  output logic                           o_param_batch_write_cmd,
  output logic      [255:0]              o_actuator_points
);
  // ---------------------------------------------------------------
  // power-on sampling
  // ---------------------------------------------------------------
  logic       sampled;
  logic       sel_low;
  logic       sel_high;
  logic [7:0] next_sum;
  logic [6:0] next_number;
  logic       next_valid;

  // decimal compose, wide enough that 129 cannot wrap
  always_comb begin
    next_sum    = 8'(i_station_tens) * 8'(brio_pkg::TENS_WEIGHT) + 8'(i_station_ones);
    next_number = next_sum[6:0];
    next_valid  = (i_station_ones <= brio_pkg::DIGIT_MAX)
                  && (next_sum >= 8'(brio_pkg::STATION_MIN))
                  && (next_sum <= 8'(brio_pkg::STATION_MAX));
  end

  // one capture after reset release, later switch moves ignored
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sampled   <= 1'b0;
      o_station <= '0;
      sel_low   <= 1'b0;
      sel_high  <= 1'b0;
    end else if (!sampled) begin
      sampled         <= 1'b1;
      o_station.number <= next_number;
      o_station.valid  <= next_valid;
      sel_low          <= i_point_count_select_low;
      sel_high         <= i_point_count_select_high;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_point_count       <= brio_pkg::POINTS_256;
      o_occupied_stations <= brio_pkg::OCC_256;
      o_cycle_code        <= brio_pkg::CYC_256;
    end else begin
      case ({sel_high, sel_low})
        2'b00: begin
          o_point_count       <= brio_pkg::POINTS_256;
          o_occupied_stations <= brio_pkg::OCC_256;
          o_cycle_code        <= brio_pkg::CYC_256;
        end
        2'b01: begin
          o_point_count       <= brio_pkg::POINTS_128;
          o_occupied_stations <= brio_pkg::OCC_128;
          o_cycle_code        <= brio_pkg::CYC_128;
        end
        2'b10: begin
          o_point_count       <= brio_pkg::POINTS_64;
          o_occupied_stations <= brio_pkg::OCC_64;
          o_cycle_code        <= brio_pkg::CYC_64;
        end
        default: begin
          o_point_count       <= brio_pkg::POINTS_32;
          o_occupied_stations <= brio_pkg::OCC_32;
          o_cycle_code        <= brio_pkg::CYC_32;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_error_led        <= 1'b0;
      o_station_accepted <= 1'b0;
    end else if (sampled) begin
      o_error_led        <= !o_station.valid || i_station_duplicate;
      o_station_accepted <= o_station.valid && !i_station_duplicate;
    end
  end

  // ---------------------------------------------------------------
  // remote output words
  // ---------------------------------------------------------------
  logic [15:0] cmd_word;
  logic [15:0] param_word;
  logic        wr_img;
  logic [3:0]  wr_idx;

  assign wr_img = i_wr_en && (i_addr >= brio_pkg::WORD_IMG_BASE)
                  && (i_addr <= brio_pkg::WORD_IMG_LAST);
  assign wr_idx = 4'(i_addr - brio_pkg::WORD_IMG_BASE);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      cmd_word   <= '0;
      param_word <= '0;
    end else if (i_wr_en && i_addr == brio_pkg::WORD_STATUS) begin
      cmd_word <= i_wdata & brio_pkg::CMD_MASK;
    end else if (i_wr_en && i_addr == brio_pkg::WORD_EVENT) begin
      param_word <= i_wdata & brio_pkg::PARAM_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_actuator_points <= '0;
    end else if (wr_img) begin
      o_actuator_points[wr_idx*brio_pkg::WORD_W +: brio_pkg::WORD_W] <= i_wdata;
    end
  end

  assign o_error_reset_request   = cmd_word[brio_pkg::BIT_ERR_RESET];
  assign o_addr_detect_command   = cmd_word[brio_pkg::BIT_ADDR_CMD];
  assign o_param_access_request  = param_word[brio_pkg::BIT_PACC_REQ];
  assign o_param_batch_read_cmd  = param_word[brio_pkg::BIT_BATCH_READ];
  assign o_param_batch_write_cmd = param_word[brio_pkg::BIT_BATCH_WRITE];

  // ---------------------------------------------------------------
  // error latches
  // ---------------------------------------------------------------
  logic reset_prev;
  logic reset_pulse;
  logic short_l;
  logic vdrop_l;
  logic disc_l;
  logic alarm_l;
  logic pacc_err_l;
  logic ready;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      reset_prev <= 1'b0;
    end else begin
      reset_prev <= o_error_reset_request;
    end
  end
  // on-then-off: clear on the falling edge of the request
  assign reset_pulse = reset_prev && !o_error_reset_request;

  // latched until cause gone and reset; a live cause wins
  // vdrop latches from power-up like any other cause
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      short_l    <= 1'b0;
      vdrop_l    <= 1'b0;
      disc_l     <= 1'b0;
      alarm_l    <= 1'b0;
      pacc_err_l <= 1'b0;
    end else begin
      short_l    <= i_event.short_err || (short_l && !reset_pulse);
      vdrop_l    <= i_event.vdrop_err || (vdrop_l && !reset_pulse);
      disc_l     <= i_event.disc_err  || (disc_l && !reset_pulse);
      alarm_l    <= i_event.alarm     || (alarm_l && !reset_pulse);
      pacc_err_l <= i_event.pacc_err  || (pacc_err_l && !reset_pulse);
    end
  end

  // ready follows test done and no failure
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ready <= 1'b0;
    end else begin
      ready <= i_test_done && !i_hw_failure;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] event_word;
  logic [3:0]  rd_idx;
  logic        rd_img;

  always_comb begin
    status_word = '0;
    status_word[brio_pkg::BIT_READY] = ready;
    status_word[brio_pkg::BIT_SHORT] = short_l;
    status_word[brio_pkg::BIT_VDROP] = vdrop_l;
    status_word[brio_pkg::BIT_DISC]  = disc_l;
  end

  always_comb begin
    event_word = '0;
    event_word[brio_pkg::BIT_ALARM]     = alarm_l;
    event_word[brio_pkg::BIT_PACC_DONE] = i_event.pacc_done;
    event_word[brio_pkg::BIT_PACC_ERR]  = pacc_err_l;
    event_word[brio_pkg::BIT_ADDR_DET]  = i_event.addr_det;
  end

  assign rd_img = (i_addr >= brio_pkg::WORD_IMG_BASE) && (i_addr <= brio_pkg::WORD_IMG_LAST);
  assign rd_idx = 4'(i_addr - brio_pkg::WORD_IMG_BASE);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd_en) begin
      if (i_addr == brio_pkg::WORD_STATUS) begin
        o_rdata <= status_word;
      end else if (i_addr == brio_pkg::WORD_EVENT) begin
        o_rdata <= event_word;
      end else if (rd_img) begin
        o_rdata <= i_sensor_points[rd_idx*brio_pkg::WORD_W +: brio_pkg::WORD_W];
      end else begin
        o_rdata <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_station_range: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_station.valid |-> (o_station.number >= 7'h01 && o_station.number <= 7'h78))
    else $error("valid station out of range");
  a_err_led: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (sampled && !o_station.valid) |=> o_error_led)
    else $error("error led not lit");
  a_station_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
    sampled |=> $stable(o_station))
    else $error("station changed after sampling");
  a_dup_refuse: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (sampled && i_station_duplicate) |=> !o_station_accepted)
    else $error("duplicate accepted");
  a_points_256: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (!sel_low && !sel_high) |=> o_point_count == 9'h100)
    else $error("default point count wrong");
  a_cmd_mask: assert property (@(posedge i_clock) disable iff (!i_rstn)
    cmd_word[15:2] == 14'h0000 && param_word[15:3] == 13'h0000)
    else $error("prohibited command bit stored");
  sequence s_err_on;
    short_l && !i_event.short_err;
  endsequence
  a_err_latch: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (s_err_on ##0 !reset_pulse) |=> short_l)
    else $error("short error dropped without reset");
  a_ready_fail: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_hw_failure |=> !status_word[0])
    else $error("ready with hardware failure");
endmodule

// File: tb/brio_master_model.sv
`timescale 1ns/1ps
// master station side: one word access per wr or rd call
module brio_master_model (
  input  wire logic        i_clock,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [6:0]       o_addr,
  output logic [15:0]      o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 7'h00;
    o_wdata = 16'h0000;
  end
  // program starts only a settle time after ready is seen
  // the one-second wait is scaled to START_WAIT cycles to keep runs short
  localparam int START_WAIT = 50;
  task automatic start_app(output logic ok);
    logic [15:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(7'h00, s);
      ok = s[0];
    end
    if (ok) repeat (START_WAIT) @(posedge i_clock);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clock) #1;
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clock) #1;
    o_wr_en = 1'b0;
    // write strobe dropped; data lines left driving the complement of the written word
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge i_clock) #1;
    o_rd_en = 1'b1;
    o_addr  = a;
    @(posedge i_clock) #1;
    o_rd_en = 1'b0;
    d = i_rdata;
  endtask
endmodule

// File: tb/brio_remote_io_map_test.sv
`timescale 1ns/1ps
module brio_remote_io_map_test;
  logic clk, rstn, dup, sw_lo, sw_hi, tdone, hwf, wr, rd;
  logic [3:0] tens, ones;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [255:0] sens, act;
  brio_pkg::brio_event_s ev;
  brio_pkg::brio_station_s stn;
  logic led, acc, erq, adc, par, pbr, pbw;
  logic [8:0] pts;
  logic [2:0] occ, cyc;
  int n_errors = 0;
  int checks_done = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  brio_remote_io_map i_dut (.i_clock(clk), .i_rstn(rstn), .i_station_tens(tens),
    .i_station_ones(ones), .i_station_duplicate(dup), .i_point_count_select_low(sw_lo),
    .i_point_count_select_high(sw_hi), .i_test_done(tdone), .i_hw_failure(hwf),
    .i_event(ev), .i_sensor_points(sens), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_error_led(led), .o_station_accepted(acc),
    .o_station(stn), .o_point_count(pts), .o_occupied_stations(occ), .o_cycle_code(cyc),
    .o_error_reset_request(erq), .o_addr_detect_command(adc),
    .o_param_access_request(par), .o_param_batch_read_cmd(pbr),
    .o_param_batch_write_cmd(pbw), .o_actuator_points(act));

  brio_master_model i_master (.i_clock(clk), .i_rdata(rdata), .o_wr_en(wr),
    .o_rd_en(rd), .o_addr(addr), .o_wdata(wdata));

  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [3:0] t, input logic [3:0] o, input logic l,
                          input logic h);
    @(posedge clk) #1;
    rstn = 1'b0;
    tens = t;
    ones = o;
    sw_lo = l;
    sw_hi = h;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_config();
    logic [3:0] tt[4] = '{4'h0, 4'h0, 4'hC, 4'hC};
    logic [3:0] oo[4] = '{4'h0, 4'h1, 4'h0, 4'h1};
    logic [8:0] ep[4] = '{9'h100, 9'h080, 9'h040, 9'h020};
    logic [2:0] eo[4] = '{brio_pkg::OCC_256, brio_pkg::OCC_128, brio_pkg::OCC_64,
                          brio_pkg::OCC_32};
    logic [2:0] ec[4] = '{brio_pkg::CYC_256, brio_pkg::CYC_128, brio_pkg::CYC_64,
                          brio_pkg::CYC_32};
    int n;
    logic ok;
    for (int i = 0; i < 4; i++) begin
      do_reset(tt[i], oo[i], i[0], i[1]);
      n = tt[i] * 10 + oo[i];
      ok = (n >= 1) && (n <= 120);
      chk(pts, ep[i]);
      chk(occ, eo[i]);
      chk(cyc, ec[i]);
      chk(stn.valid, ok);
      chk(led, !ok);
      if (ok) chk(stn.number, n[6:0]);
    end
    tens = 4'h0;
    ones = 4'h5;
    sw_lo = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(stn.number, 7'h79);
    chk(stn.valid, 1'b0);
    chk(pts, 9'h020);
    do_reset(4'hC, 4'h9, 1'b0, 1'b0);
    chk(stn.valid, 1'b0);
    chk(led, 1'b1);
    dup = 1'b1;
    do_reset(4'h0, 4'h1, 1'b0, 1'b0);
    chk(acc, 1'b0);
    chk(led, 1'b1);
    dup = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(acc, 1'b1);
  endtask

  task automatic t_status();
    logic ok;
    i_master.start_app(ok);
    chk(ok, 1'b1);
    if (!ok) wrap_up();
    i_master.rd(7'h00, v);
    chk(v, 16'h0001);
    @(posedge clk) #1;
    ev.short_err = 1'b1;
    ev.vdrop_err = 1'b1;
    ev.disc_err = 1'b1;
    @(posedge clk) #1;
    ev = '0;
    i_master.rd(7'h00, v);
    chk(v, 16'h001B);
    i_master.wr(7'h00, 16'h0001);
    chk(erq, 1'b1);
    i_master.rd(7'h00, v);
    chk(v, 16'h001B);
    i_master.wr(7'h00, 16'h0000);
    repeat (2) @(posedge clk);
    i_master.rd(7'h00, v);
    chk(v, 16'h0001);
    hwf = 1'b1;
    i_master.rd(7'h00, v);
    chk(v[0], 1'b0);
    hwf = 1'b0;
    tdone = 1'b0;
    i_master.rd(7'h00, v);
    chk(v[0], 1'b0);
    tdone = 1'b1;
  endtask

  task automatic t_events();
    ev.alarm = 1'b1;
    ev.pacc_done = 1'b1;
    ev.pacc_err = 1'b1;
    ev.addr_det = 1'b1;
    i_master.rd(7'h01, v);
    chk(v, 16'h0017);
    ev = '0;
    i_master.rd(7'h01, v);
    chk(v, 16'h0005);
  endtask

  task automatic t_commands();
    i_master.wr(7'h00, 16'hFFFE);
    chk({erq, adc}, 2'b01);
    i_master.wr(7'h01, 16'hFFFF);
    chk({par, pbr, pbw}, 3'b111);
    i_master.wr(7'h01, 16'hFFFA);
    chk({par, pbr, pbw}, 3'b010);
  endtask

  task automatic t_image();
    sens = '0;
    sens[0] = 1'b1;
    sens[17] = 1'b1;
    sens[255] = 1'b1;
    i_master.rd(7'h04, v);
    chk(v, 16'h0001);
    i_master.rd(7'h05, v);
    chk(v, 16'h0002);
    i_master.rd(7'h13, v);
    chk(v, 16'h8000);
    i_master.rd(7'h14, v);
    chk(v, 16'h0000);
    i_master.wr(7'h04, 16'hA5A5);
    i_master.wr(7'h13, 16'h1234);
    i_master.wr(7'h14, 16'hFFFF);
    i_master.wr(7'h02, 16'hFFFF);
    @(posedge clk) #1;
    chk(act, {16'h1234, 224'h0, 16'hA5A5});
  endtask

  initial begin
    rstn = 1'b0;
    {tens, ones, dup, sw_lo, sw_hi, hwf} = '0;
    tdone = 1'b1;
    ev = '0;
    sens = '0;
    t_config();
    do_reset(4'h0, 4'h7, 1'b0, 1'b0);
    t_status();
    t_events();
    t_commands();
    t_image();
    wrap_up();
  end

  // hang guard: far beyond the length of the sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
